/* rtl/csio_map.vh */
`ifndef CSIO_MAP_VH
`define CSIO_MAP_VH
// Function
// - Ext clock and handshake: ready drives output low
// - Ready output returns high when reception starts
// - Internal clock: handshake output stays inactive
// - Polarity 0 launch falling, sample rising; 1 reversed
// - Send needs enable, buffer full, and clear-to-send low when CTS is enabled
// - Receiving runs transmitter, dummy data shifts out
// - Internal clock runs after enable and buffer write
// - External clock: shifting follows applied clock edges
// - New word over unread data sets overrun
// - Overrun leaves receive interrupt flag unchanged
// - Receive needs receive enable, transmit enable, data

// Register word indices; the byte address is four times the index
`define A_MODE      4'h0
`define A_TXRX      4'h1
`define A_TXBUF     4'h2
`define A_RXBUF     4'h3
`define A_IRQ_STAT  4'h4
`define A_IRQ_EN    4'h5
`define A_IRQ_CLR   4'h6
// Mode register fields
`define B_EXT_CLK   0
`define B_POL       1
`define B_RTS_EN    2
`define B_CTS_EN    3
`define F_DIV_LO    8
`define F_DIV_HI    15
// Control register fields
`define B_TE        0
`define B_TI        1
`define B_RE        2
`define B_RXFULL    3
`define B_OER       4
// Interrupt status bits
`define I_TX        0
`define I_RX        1
`define I_OER       2
// Reset values
`define MODE_RST    32'h0000_0400
`define DIV_RST     8'h04
// Bench link clock timing
`define LINK_PER_NS 400
`define CLK_PER_NS  50
`endif

/* rtl/pin_sync.v */
`timescale 1ns/10ps
// Three-stage synchroniser; a change is accepted once stages two and three agree
module pin_sync #(
  parameter RST_VAL = 1'b1
) (
  input  wire clk,
  input  wire rstn,
  input  wire din,
  output reg  dout
);
  reg s1_r; // Metastability catcher, read only by s2_r
  reg s2_r;
  reg s3_r;

  // Shift chain and agreement filter
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      dout <= RST_VAL;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        dout <= s3_r; // Agreement: take the new level
    end
  end
endmodule // pin_sync

/* rtl/irq_block.v */
`timescale 1ns/10ps
`include "csio_map.vh"
// Sticky status, enable mask and write-one-to-clear; set wins over clear
module irq_block #(
  parameter N = 3
) (
  input  wire         clk,
  input  wire         rstn,
  input  wire [N-1:0] evt,
  input  wire [N-1:0] en,
  input  wire [N-1:0] clr,
  output reg  [N-1:0] stat_r,
  output reg          irq_r
);
  wire [N-1:0] stat_nxt;
  genvar g;

  // Per-bit sticky flag
  generate
    for (g = 0; g < N; g = g + 1)
    begin : g_bit
      assign stat_nxt[g] = evt[g] | (stat_r[g] & ~clr[g]);
    end
  endgenerate

  // Status and registered level interrupt
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stat_r <= {N{1'b0}};
      irq_r  <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      irq_r  <= |(stat_nxt & en);
    end
  end
endmodule // irq_block

/* rtl/clock_sync_serial_port.v */
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "csio_map.vh"
// Clock-synchronous serial channel with AHB-Lite register slave
module clock_sync_serial_port #(
  parameter NBITS = 8
) (
  input  wire        clk,
  input  wire        rstn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Serial link
  input  wire        shift_clock_pin_i,
  output reg         shift_clock_pin_o,
  output reg         shift_clock_pin_oe,
  output reg         serial_data_out_pin,
  input  wire        serial_data_in_pin,
  input  wire        clear_to_send_n,
  output reg         request_to_send_n,
  output wire        irq
);
  localparam S_IDLE  = 2'd0;
  localparam S_SHIFT = 2'd1;
  localparam S_DONE  = 2'd2;

  // Mode and control state
  reg [31:0]      mode_r;          // Clock source, polarity, handshake, divider
  reg             te_r;            // transmit_enable_bit
  reg             re_r;            // receive_enable_bit
  reg             ti_r;            // transmit_buffer_empty_flag
  reg             rxfull_r;        // Unread data in receive buffer
  reg             oer_r;           // overrun_error_flag
  reg [NBITS-1:0] txbuf_r;         // transmit_buffer
  reg [NBITS-1:0] rxbuf_r;         // receive_buffer
  reg [NBITS-1:0] tsr_r;           // Transmit shift register
  reg [NBITS-1:0] rsr_r;           // Receive shift register
  reg [3:0]       bitcnt_r;        // Bits left in the frame
  reg [1:0]       state_r;
  reg             rx_frame_r;      // Frame counts as reception
  reg [7:0]       divcnt_r;        // Internal clock half-period counter
  reg             iclk_r;          // Internal shift clock level
  reg             sck_d_r;         // Previous shift clock level for edges
  reg [2:0]       irq_en_r;
  // AHB address phase capture
  reg             wr_pend_r;
  reg             rd_pend_r;
  reg [3:0]       aidx_r;
  // Event pulses to interrupt block
  reg             ev_tx_r;
  reg             ev_rx_r;
  reg             ev_oer_r;
  reg [2:0]       clr_r;

  wire [2:0] irq_stat;
  wire       ext_clk = mode_r[`B_EXT_CLK];
  wire       pol     = mode_r[`B_POL];
  wire       rts_en  = mode_r[`B_RTS_EN];
  wire       cts_en  = mode_r[`B_CTS_EN];
  wire [7:0] div     = mode_r[`F_DIV_HI:`F_DIV_LO];
  wire       sck_ext;
  wire       cts_s;
  wire       rxd_s;

  // Word index decode shared by read and write paths.
  // Only the first eight words answer; anything above decodes to an
  // index that no register claims, so stray reads return zero.
  function [3:0] widx;
    input [31:0] a;
    begin
      widx = (a[31:5] == 27'h0) ? {1'b0, a[4:2]} : 4'hf;
    end
  endfunction

  // Pins from the far side: four flops each, a change counts on agreement
  pin_sync #(.RST_VAL(1'b1)) u_sck (
    .clk  (clk),
    .rstn (rstn),
    .din  (shift_clock_pin_i),
    .dout (sck_ext)
  );
  pin_sync #(.RST_VAL(1'b1)) u_cts (
    .clk  (clk),
    .rstn (rstn),
    .din  (clear_to_send_n),
    .dout (cts_s)
  );
  pin_sync #(.RST_VAL(1'b1)) u_rxd (
    .clk  (clk),
    .rstn (rstn),
    .din  (serial_data_in_pin),
    .dout (rxd_s)
  );

  // Sticky interrupt status; events are one-cycle pulses from the engine
  irq_block #(.N(3)) u_irq (
    .clk    (clk),
    .rstn   (rstn),
    .evt    ({ev_oer_r, ev_rx_r, ev_tx_r}),
    .en     (irq_en_r),
    .clr    (clr_r),
    .stat_r (irq_stat),
    .irq_r  (irq)
  );

  // Active shift clock level: pin when external, divider when internal
  wire sck      = ext_clk ? sck_ext : iclk_r;
  wire sck_rise = sck & ~sck_d_r;
  wire sck_fall = ~sck & sck_d_r;
  // Launch edge falls when polarity is 0, sample edge rises; reversed at 1
  wire launch_e = pol ? sck_rise : sck_fall;
  wire sample_e = pol ? sck_fall : sck_rise;
  // Start conditions; idle clock level is guaranteed by the far end
  wire cts_ok   = ~cts_en | ~cts_s;
  wire go       = te_r & ~ti_r & cts_ok;
  wire rx_go    = re_r & te_r & ~ti_r;
  // Address phase accepted; hready keeps a stalled earlier transfer out
  wire bus_take = hsel & htrans[1] & hready;
  wire wr_tx    = wr_pend_r & (aidx_r == `A_TXBUF);

  // AHB-Lite slave: zero wait states, always OKAY
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      aidx_r    <= 4'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= bus_take & hwrite;
      rd_pend_r <= bus_take & ~hwrite;
      aidx_r    <= widx(haddr);
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (bus_take & ~hwrite)
      begin
        // Read data registered during address phase, valid in data phase
        case (widx(haddr))
          `A_MODE:     hrdata <= mode_r;
          `A_TXRX:     hrdata <= {27'h0, oer_r, rxfull_r, re_r, ti_r, te_r};
          `A_TXBUF:    hrdata <= {{(32-NBITS){1'b0}}, txbuf_r};
          `A_RXBUF:    hrdata <= {{(32-NBITS){1'b0}}, rxbuf_r};
          `A_IRQ_STAT: hrdata <= {29'h0, irq_stat};
          `A_IRQ_EN:   hrdata <= {29'h0, irq_en_r};
          default:     hrdata <= 32'h0000_0000; // Unmapped and write-only
        endcase
      end
    end
  end

  // Configuration writes and clear strobe
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_r   <= `MODE_RST;
      te_r     <= 1'b0;
      re_r     <= 1'b0;
      irq_en_r <= 3'h0;
      txbuf_r  <= {NBITS{1'b0}};
      clr_r    <= 3'h0;
    end
    else
    begin
      clr_r <= 3'h0;
      if (wr_pend_r)
      begin
        case (aidx_r)
          `A_MODE:    mode_r   <= hwdata;
          `A_TXRX:
          begin
            te_r <= hwdata[`B_TE];
            re_r <= hwdata[`B_RE];
          end
          `A_TXBUF:   txbuf_r  <= hwdata[NBITS-1:0]; // Low byte carries dummy data
          `A_IRQ_EN:  irq_en_r <= hwdata[2:0];
          `A_IRQ_CLR: clr_r    <= hwdata[2:0];
          default:    clr_r    <= 3'h0;
        endcase
      end
    end
  end

  // Internal clock divider; idles at the polarity-dependent level
  // Half period is the divider plus one system clock; zero gives clk/2
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      divcnt_r <= 8'h00;
      iclk_r   <= 1'b1;
      sck_d_r  <= 1'b1;
    end
    else
    begin
      sck_d_r <= sck;
      if (state_r != S_SHIFT || ext_clk)
      begin
        divcnt_r <= 8'h00;
        iclk_r   <= ~pol; // Idle level: high for polarity 0
      end
      else if (divcnt_r >= div)
      begin
        divcnt_r <= 8'h00;
        iclk_r   <= ~iclk_r; // Clock runs only while a frame is active
      end
      else
        divcnt_r <= divcnt_r + 8'h01;
    end
  end

  // Shift engine and buffer flags
  // One frame at a time: the transmitter always runs, reception rides along
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r             <= S_IDLE;
      ti_r                <= 1'b1;
      rxfull_r            <= 1'b0;
      oer_r               <= 1'b0;
      tsr_r               <= {NBITS{1'b0}};
      rsr_r               <= {NBITS{1'b0}};
      rxbuf_r             <= {NBITS{1'b0}};
      bitcnt_r            <= 4'h0;
      rx_frame_r          <= 1'b0;
      serial_data_out_pin <= 1'b1;
      ev_tx_r             <= 1'b0;
      ev_rx_r             <= 1'b0;
      ev_oer_r            <= 1'b0;
    end
    else
    begin
      ev_tx_r  <= 1'b0;
      ev_rx_r  <= 1'b0;
      ev_oer_r <= 1'b0;
      // Reading the receive buffer frees it
      if (rd_pend_r && aidx_r == `A_RXBUF)
        rxfull_r <= 1'b0;
      if (wr_tx)
        ti_r <= 1'b0; // Software write fills buffer
      if (wr_pend_r && aidx_r == `A_TXRX && hwdata[`B_OER])
        oer_r <= 1'b0;
      case (state_r)
        S_IDLE:
        begin
          if (go && !wr_tx)
          begin
            // Transmitter always runs; receive rides on dummy data
            tsr_r      <= txbuf_r;
            ti_r       <= 1'b1; // Moved into shift register
            ev_tx_r    <= 1'b1;
            rx_frame_r <= rx_go;
            bitcnt_r   <= NBITS[3:0];
            state_r    <= S_SHIFT;
            serial_data_out_pin <= txbuf_r[0];
          end
        end
        S_SHIFT:
        begin
          // Shifting advances only on clock edges
          if (sample_e)
          begin
            rsr_r    <= {rxd_s, rsr_r[NBITS-1:1]};
            bitcnt_r <= bitcnt_r - 4'h1;
            if (bitcnt_r == 4'h1)
              state_r <= S_DONE;
          end
          // Bit 0 already stands from the start of the frame, so the first
          // launch edge only opens the bit; later launch edges move on
          if (launch_e && bitcnt_r != NBITS[3:0])
          begin
            tsr_r               <= {1'b1, tsr_r[NBITS-1:1]};
            serial_data_out_pin <= tsr_r[1];
          end
          // Clearing transmit enable abandons a frame whose external clock
          // stopped; without it the engine would wait for edges forever
          if (!te_r)
            state_r <= S_IDLE;
        end
        S_DONE:
        begin
          state_r <= S_IDLE;
          if (rx_frame_r)
          begin
            rxbuf_r <= rsr_r;
            if (rxfull_r && !(rd_pend_r && aidx_r == `A_RXBUF))
            begin
              oer_r    <= 1'b1; // Word over unread data
              ev_oer_r <= 1'b1; // Receive flag untouched on overrun
            end
            else
            begin
              rxfull_r <= 1'b1;
              ev_rx_r  <= 1'b1;
            end
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  // Ready handshake and clock pin drive
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      request_to_send_n  <= 1'b1;
      shift_clock_pin_o  <= 1'b1;
      shift_clock_pin_oe <= 1'b0;
    end
    else
    begin
      shift_clock_pin_o  <= iclk_r;
      shift_clock_pin_oe <= ~ext_clk;
      if (!ext_clk || !rts_en)
        request_to_send_n <= 1'b1; // No effect with internal clock
      else if (state_r == S_IDLE)
        request_to_send_n <= ~(rx_go & ~rxfull_r); // Ready to accept
      // A reception frame is armed but the far end has not clocked yet:
      // ready stays low so a handshaking sender starts the clock
      else if (state_r == S_SHIFT && rx_frame_r && !rxfull_r &&
               bitcnt_r == NBITS[3:0] && sck == ~pol)
        request_to_send_n <= 1'b0;
      else
        request_to_send_n <= 1'b1; // Reception under way
    end
  end
endmodule // clock_sync_serial_port

/* tb/csio_checker_asserts.sv */
`timescale 1ns/10ps
module csio_checker #(
  parameter NBITS = 8
) (
  input wire        clk,
  input wire        rstn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        shift_clock_pin_i,
  input wire        shift_clock_pin_o,
  input wire        shift_clock_pin_oe,
  input wire        serial_data_out_pin,
  input wire        request_to_send_n,
  input wire        irq
);
  reg       sck_q_r; // Last seen external clock level
  reg [3:0] since_r; // Cycles since that clock last moved, saturating
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Age of the last external clock edge
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sck_q_r <= 1'b1;
      since_r <= 4'hf;
    end
    else
    begin
      sck_q_r <= shift_clock_pin_i;
      if (sck_q_r != shift_clock_pin_i)
        since_r <= 4'h0;
      else if (since_r != 4'hf)
        since_r <= since_r + 4'h1;
    end
  end
  // Read of an unmapped word
  sequence rd_unmapped;
    hsel && htrans[1] && hready && !hwrite && haddr == 32'h40;
  endsequence
  // Its data phase carries zero
  sequence data_zero;
    hrdata == 32'h0;
  endsequence
  // Outputs at their idle levels
  sequence out_idle;
    request_to_send_n && serial_data_out_pin && !irq;
  endsequence
  // An external clock edge while the clock pin is an input
  sequence ext_edge;
    !shift_clock_pin_oe && $changed(shift_clock_pin_i);
  endsequence
  // Ready released within the pin synchroniser's latency
  sequence ready_off;
    ##[0:8] request_to_send_n;
  endsequence
  // Internal clock or data moved while the clock pin is driven
  sequence int_clk_move;
    shift_clock_pin_oe && $changed(shift_clock_pin_o);
  endsequence
  sequence int_bit_move;
    shift_clock_pin_oe && $changed(serial_data_out_pin);
  endsequence
  // Data moved while the clock comes from outside
  sequence ext_bit_move;
    !shift_clock_pin_oe && $changed(serial_data_out_pin);
  endsequence
  a_unmapped_zero: assert property (rd_unmapped |=> data_zero)
    else $error("unmapped read not zero");
  a_zero_wait: assert property (hreadyout) else $error("wait state seen");
  a_okay_resp: assert property (!hresp) else $error("error response seen");
  a_reset_idle: assert property ($rose(rstn) |-> out_idle)
    else $error("outputs not idle after reset");
  a_rts_internal: assert property (shift_clock_pin_oe |-> request_to_send_n)
    else $error("ready low with internal clock");
  a_rts_start: assert property (ext_edge |-> ready_off)
    else $error("ready still low after clock edge");
  a_clk_half: assert property (int_clk_move |=> $stable(shift_clock_pin_o)[*4])
    else $error("internal half period short");
  a_bit_hold: assert property (int_bit_move |=> $stable(serial_data_out_pin)[*4])
    else $error("data moved before sample edge");
  a_ext_follow: assert property (ext_bit_move |-> since_r < 4'd10)
    else $error("data moved without external edge");
endmodule // csio_checker
bind clock_sync_serial_port csio_checker #(.NBITS(NBITS)) u_chk (.clk, .rstn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .shift_clock_pin_i, .shift_clock_pin_o,
  .shift_clock_pin_oe, .serial_data_out_pin, .request_to_send_n, .irq);

/* tb/link_peer.sv */
`timescale 1ns/10ps
// Far-side device supplying the external clock, 400 ns period
module link_peer (
  input  wire       go,
  input  wire       pol,
  input  wire       use_rts,
  input  wire       rts_n,
  input  wire       sdo,
  input  wire [7:0] tx_word,
  output wire       sck,
  output reg        sdi,
  output reg  [7:0] rx_word,
  output reg        done
);
  reg     busy;
  reg     sck_r;
  integer i;
  // Clock stands at the idle level outside frames
  assign sck = busy ? sck_r : !pol;
  initial
  begin
    busy = 0;
    sck_r = 1;
    sdi = 1;
    rx_word = 0;
    done = 1;
  end
  // One frame per go pulse, LSB first
  always @(posedge go)
  begin
    done = 0;
    if (use_rts)
      wait (!rts_n); // Only send once the receiver is ready
    busy = 1;
    sck_r = !pol;
    #212; // Lead-in half period, kept off the system clock edge
    for (i = 0; i < 8; i = i + 1)
    begin
      sck_r = pol; // Launch edge
      sdi = tx_word[i];
      #200 sck_r = !pol; // Sample edge
      #190 rx_word = {sdo, rx_word[7:1]}; // Late capture covers the pin sync delay
      #10;
    end
    busy = 0;
    sdi = ~sdi; // Released line must not look like held data
    done = 1;
  end
endmodule // link_peer

/* tb/clock_sync_serial_port_bench.sv */
`timescale 1ns/10ps
module clock_sync_serial_port_bench;
  reg         clk, rstn, hsel, hwrite, cts_n, p_go, p_pol, p_rts, sck_d;
  reg  [31:0] haddr, hwdata, rd_v;
  reg  [1:0]  htrans;
  reg  [7:0]  p_tx, cap;
  wire [31:0] hrdata;
  wire [7:0]  p_rx;
  wire        hrdy, hresp, sck_o, sck_oe, sdo, rts_n, irq, p_sck, p_sdi, p_done;
  integer     mismatches, compares, nb, i;
  wire        sck_pin = sck_oe ? sck_o : p_sck; // Own drive wins when enabled
  always #25 clk = ~clk;
  clock_sync_serial_port dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hrdy),
    .hrdata(hrdata), .hreadyout(hrdy), .hresp(hresp), .shift_clock_pin_i(sck_pin),
    .shift_clock_pin_o(sck_o), .shift_clock_pin_oe(sck_oe), .serial_data_out_pin(sdo),
    .serial_data_in_pin(p_sdi), .clear_to_send_n(cts_n), .request_to_send_n(rts_n), .irq(irq));
  link_peer peer (.go(p_go), .pol(p_pol), .use_rts(p_rts), .rts_n(rts_n), .sdo(sdo),
    .tx_word(p_tx), .sck(p_sck), .sdi(p_sdi), .rx_word(p_rx), .done(p_done));
  // Capture output bits on internal rising edges
  always @(posedge clk)
  begin
    sck_d <= sck_o;
    if (sck_oe && sck_o && !sck_d)
    begin
      cap <= {sdo, cap[7:1]};
      nb <= nb + 1;
    end
  end
  task chk(input [31:0] s, input [31:0] e);
  begin
    compares = compares + 1;
    if (s !== e)
    begin
      mismatches = mismatches + 1;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  end
  endtask
  // Single AHB-Lite transfer, waits on ready in both phases
  task bus(input [31:0] a, input [31:0] d, input w);
  begin
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (!hrdy) @(posedge clk);
    htrans <= 2'b00;
    hsel <= 0;
    hwdata <= d;
    @(posedge clk);
    while (!hrdy) @(posedge clk);
    rd_v = hrdata;
  end
  endtask
  task rd_chk(input [31:0] a, input [31:0] e);
  begin
    bus(a, 32'h0, 0);
    chk(rd_v, e);
  end
  endtask
  // One external-clock frame; dummy byte written first every time
  task frame(input [7:0] d, input [7:0] w, input r);
  begin
    p_tx <= w;
    p_rts <= r;
    bus(32'h8, {24'h0, d}, 1);
    repeat (8) @(posedge clk);
    if (r) chk(32'(rts_n), 32'h0);
    p_go <= 1;
    @(posedge clk);
    p_go <= 0;
    for (i = 0; i < 3000 && !p_done; i = i + 1) @(posedge clk);
    chk(32'(p_done), 32'h1);
  end
  endtask
  task s_internal;
  begin
    bus(32'h0, 32'h040c, 1);
    cts_n <= 1;
    bus(32'h4, 32'h1, 1);
    nb = 0;
    bus(32'h8, 32'h96, 1);
    repeat (40) @(posedge clk);
    chk(nb, 0);
    rd_chk(32'h4, 32'h1);
    chk(32'(rts_n), 32'h1);
    cts_n <= 0;
    for (i = 0; i < 400 && nb < 8; i = i + 1) @(posedge clk);
    chk({24'h0, cap}, 32'h96);
    repeat (20) @(posedge clk);
    rd_chk(32'h4, 32'h3);
    rd_chk(32'h10, 32'h1);
    bus(32'h14, 32'h1, 1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    bus(32'h14, 32'h0, 1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    bus(32'h18, 32'h1, 1);
    bus(32'h14, 32'h7, 1);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
  end
  endtask
  task s_ext;
  begin
    p_pol <= 1;
    bus(32'h0, 32'h0407, 1);
    bus(32'h4, 32'h5, 1);
    frame(8'ha5, 8'h3c, 1);
    chk({24'h0, p_rx}, 32'ha5);
    chk(32'(rts_n), 32'h1);
    rd_chk(32'hc, 32'h3c);
    rd_chk(32'h10, 32'h3);
  end
  endtask
  task s_overrun;
  begin
    bus(32'h0, 32'h0403, 1);
    frame(8'hff, 8'h11, 0);
    bus(32'h18, 32'h7, 1);
    frame(8'hff, 8'h81, 0);
    rd_chk(32'h4, 32'h1f);
    rd_chk(32'h10, 32'h5);
  end
  endtask
  task stop_test;
  begin
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  initial
  begin
    {clk, rstn, hsel, hwrite, cts_n, p_go, p_pol, p_rts, sck_d} = 0;
    {haddr, hwdata, htrans, p_tx, cap} = 0;
    {mismatches, compares, nb} = 0;
    repeat (10) @(posedge clk);
    rstn <= 1;
    rd_chk(32'h4, 32'h2);
    chk(32'(rts_n), 32'h1);
    rd_chk(32'h40, 32'h0);
    s_internal;
    s_ext;
    s_overrun;
    stop_test;
  end
  // Hang guard, far beyond the few frames above
  initial
  begin
    #1000000;
    mismatches = mismatches + 1;
    stop_test;
  end
endmodule // clock_sync_serial_port_bench
